// ---- hdl/fidr_pkg.sv ----
package fidr_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCLK_HALF_NS  = 80;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // opcodes and fixed fields
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_ID_DUAL     = 8'h92;
   localparam logic [7:0] OP_ID_QUAD     = 8'h94;
   localparam logic [7:0] OP_UNIQUE_ID   = 8'h4b;
   localparam logic [7:0] OP_STD_ID      = 8'h9f;
   localparam logic [7:0] OP_DISC_READ   = 8'h5a;
   localparam logic [7:0] HOST_MODE_BITS = 8'hf0;

   // ---------------------------------------------------------------
   // phase lengths in serial clocks
   // ---------------------------------------------------------------
   localparam logic [5:0] CMD_CLK_SPI    = 6'd8;
   localparam logic [5:0] CMD_CLK_FOUR   = 6'd2;
   localparam logic [5:0] ADDR_CLK_DUAL  = 6'd16;
   localparam logic [5:0] ADDR_CLK_QUAD  = 6'd8;
   localparam logic [5:0] ADDR_CLK_DISC  = 6'd24;
   localparam logic [5:0] DUMMY_CLK_QUAD = 6'd4;
   localparam logic [5:0] DUMMY_CLK_DISC = 6'd8;
   localparam logic [5:0] DUMMY_CLK_UID3 = 6'd32;
   localparam logic [5:0] DUMMY_CLK_UID4 = 6'd40;

   typedef enum logic [2:0] {
      PH_CMD   = 3'b000,
      PH_ADDR  = 3'b001,
      PH_DUMMY = 3'b011,
      PH_DATA  = 3'b010,
      PH_SKIP  = 3'b110
   } fidr_phase_t;

   // ---------------------------------------------------------------
   // per-opcode decode
   // ---------------------------------------------------------------
   function automatic logic [2:0] cmd_width(input logic four_line);
      return four_line ? 3'd4 : 3'd1;
   endfunction : cmd_width

   function automatic logic [5:0] cmd_clocks(input logic four_line);
      return four_line ? CMD_CLK_FOUR : CMD_CLK_SPI;
   endfunction : cmd_clocks

   function automatic logic op_accepted(input logic [7:0] op, input logic four_line);
      if (four_line)
         return op == OP_STD_ID;
      return op inside {OP_ID_DUAL, OP_ID_QUAD, OP_UNIQUE_ID, OP_STD_ID, OP_DISC_READ};
   endfunction : op_accepted

   function automatic logic [2:0] addr_width(input logic [7:0] op);
      case (op)
         OP_ID_DUAL: return 3'd2;
         OP_ID_QUAD: return 3'd4;
         default:    return 3'd1;
      endcase
   endfunction : addr_width

   function automatic logic [5:0] addr_clocks(input logic [7:0] op);
      case (op)
         OP_ID_DUAL:   return ADDR_CLK_DUAL;
         OP_ID_QUAD:   return ADDR_CLK_QUAD;
         OP_DISC_READ: return ADDR_CLK_DISC;
         default:      return 6'd0;
      endcase
   endfunction : addr_clocks

   function automatic logic [5:0] dummy_clocks(input logic [7:0] op, input logic four_byte);
      case (op)
         OP_ID_QUAD:   return DUMMY_CLK_QUAD;
         OP_DISC_READ: return DUMMY_CLK_DISC;
         OP_UNIQUE_ID: return four_byte ? DUMMY_CLK_UID4 : DUMMY_CLK_UID3;
         default:      return 6'd0;
      endcase
   endfunction : dummy_clocks

   function automatic logic [2:0] data_width(input logic [7:0] op, input logic four_line);
      case (op)
         OP_ID_DUAL: return 3'd2;
         OP_ID_QUAD: return 3'd4;
         OP_STD_ID:  return four_line ? 3'd4 : 3'd1;
         default:    return 3'd1;
      endcase
   endfunction : data_width

   // ---------------------------------------------------------------
   // lane mapping: single-wire host data on dq0, device data on dq1
   // ---------------------------------------------------------------
   function automatic logic [3:0] lane_pack(input logic [7:0] b, input logic [2:0] w,
                                            input logic on_do);
      case (w)
         3'd4:    return b[7:4];
         3'd2:    return {2'b00, b[7:6]};
         default: return on_do ? {2'b00, b[7], 1'b0} : {3'b000, b[7]};
      endcase
   endfunction : lane_pack

   function automatic logic [3:0] lane_oe(input logic [2:0] w, input logic on_do);
      case (w)
         3'd4:    return 4'hf;
         3'd2:    return 4'h3;
         default: return on_do ? 4'h2 : 4'h1;
      endcase
   endfunction : lane_oe

   function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] dq,
                                            input logic [2:0] w, input logic from_do);
      case (w)
         3'd4:    return {sr[27:0], dq};
         3'd2:    return {sr[29:0], dq[1:0]};
         default: return {sr[30:0], from_do ? dq[1] : dq[0]};
      endcase
   endfunction : shift_in

endpackage : fidr_pkg

// ---- hdl/fidr_link_if.sv ----
`timescale 1ns/10ps
interface fidr_link_if;
   logic       cs_b;
   logic       sclk;
   logic [3:0] dq_h_o;
   logic [3:0] dq_h_oe;
   logic [3:0] dq_d_o;
   logic [3:0] dq_d_oe;
   logic [3:0] dq;

   // wire level, released lines pulled high
   assign dq = (dq_d_oe & dq_d_o) | (~dq_d_oe & dq_h_oe & dq_h_o) | (~dq_d_oe & ~dq_h_oe);

   modport dev  (input cs_b, sclk, dq, output dq_d_o, dq_d_oe);
   modport host (output cs_b, sclk, dq_h_o, dq_h_oe, input dq);
endinterface : fidr_link_if

// ---- hdl/fidr_host.sv ----
`timescale 1ns/10ps
module fidr_host
   import fidr_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // flash link
   fidr_link_if.host        link,
   // request
   input  wire logic        start,
   input  wire logic [7:0]  cmd_op,
   input  wire logic [23:0] cmd_addr,
   input  wire logic [7:0]  read_len,
   input  wire logic        four_line_command_mode,
   input  wire logic        four_byte_addr_mode,
   // answer
   output logic             busy_q,
   output logic [7:0]       rd_data_q,
   output logic             rd_valid_q
);

   typedef enum logic [2:0] {
      H_IDLE  = 3'b000,
      H_CMD   = 3'b001,
      H_ADDR  = 3'b011,
      H_DUMMY = 3'b010,
      H_DATA  = 3'b110,
      H_END   = 3'b111
   } fidr_hstate_t;

   fidr_hstate_t state_q;
   logic [3:0]   div_q;
   logic         sclk_q;
   logic         cs_b_q;
   logic [3:0]   dq_o_q;
   logic [3:0]   dq_oe_q;
   logic [7:0]   op_q;
   logic [39:0]  tx_q;
   logic [5:0]   cnt_q;
   logic [7:0]   rx_q;
   logic [3:0]   rbit_q;
   logic [8:0]   left_q;
   logic         tick;
   logic         rise_t;
   logic         fall_t;
   logic [2:0]   w;
   logic [31:0]  rx_next;
   logic         last_bit;
   logic [23:0]  addr_sent;

   assign link.cs_b    = cs_b_q;
   assign link.sclk    = sclk_q;
   assign link.dq_h_o  = dq_o_q;
   assign link.dq_h_oe = dq_oe_q;

   assign tick     = div_q == 4'(SCLK_HALF_CYC - 1);
   assign rise_t   = tick & ~sclk_q & (state_q != H_IDLE) & (state_q != H_END);
   assign fall_t   = tick & sclk_q & (state_q != H_IDLE) & (state_q != H_END);
   assign rx_next  = shift_in({24'h0, rx_q}, link.dq, w, 1'b1);
   assign last_bit = (state_q == H_DATA) && ({1'b0, rbit_q} + {2'b00, w} == 5'd8)
                     && (left_q == 9'd1);
   assign addr_sent = (cmd_op == OP_DISC_READ) ? {16'h0000, cmd_addr[7:0]} : cmd_addr;

   always_comb begin
      unique case (state_q)
         H_CMD:   w = cmd_width(four_line_command_mode);
         H_ADDR:  w = addr_width(op_q);
         H_DATA:  w = data_width(op_q, four_line_command_mode);
         default: w = 3'd1;
      endcase
   end

   // ---------------------------------------------------------------
   // serial clock divider
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q  <= 4'h0;
         sclk_q <= 1'b0;
      end else if (state_q == H_IDLE) begin
         div_q  <= 4'h0;
         sclk_q <= 1'b0;
      end else if (tick) begin
         div_q  <= 4'h0;
         sclk_q <= (state_q == H_END) ? 1'b0 : ~sclk_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // frame sequencer and transmit lanes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= H_IDLE;
         cs_b_q  <= 1'b1;
         dq_o_q  <= 4'h0;
         dq_oe_q <= 4'h0;
         op_q    <= 8'h00;
         tx_q    <= 40'h0;
         cnt_q   <= 6'd0;
         busy_q  <= 1'b0;
      end else begin
         unique case (state_q)
            H_IDLE: if (start) begin
               op_q    <= cmd_op;
               tx_q    <= {cmd_op, addr_sent, HOST_MODE_BITS}
                          << cmd_width(four_line_command_mode);
               dq_o_q  <= lane_pack(cmd_op, cmd_width(four_line_command_mode), 1'b0);
               dq_oe_q <= lane_oe(cmd_width(four_line_command_mode), 1'b0);
               cs_b_q  <= 1'b0;
               cnt_q   <= 6'd0;
               busy_q  <= 1'b1;
               state_q <= H_CMD;
            end
            H_END: if (tick) begin
               cs_b_q  <= 1'b1;
               dq_oe_q <= 4'h0;
               busy_q  <= 1'b0;
               state_q <= H_IDLE;
            end
            default: begin
               if (rise_t) begin
                  cnt_q <= cnt_q + 6'd1;
                  if (state_q == H_CMD && cnt_q == cmd_clocks(four_line_command_mode) - 6'd1)
                  begin
                     cnt_q <= 6'd0;
                     if (addr_clocks(op_q) != 6'd0)
                        state_q <= H_ADDR;
                     else if (dummy_clocks(op_q, four_byte_addr_mode) != 6'd0)
                        state_q <= H_DUMMY;
                     else
                        state_q <= H_DATA;
                  end else if (state_q == H_ADDR && cnt_q == addr_clocks(op_q) - 6'd1) begin
                     cnt_q   <= 6'd0;
                     state_q <= (dummy_clocks(op_q, four_byte_addr_mode) != 6'd0) ? H_DUMMY
                                                                                  : H_DATA;
                  end else if (state_q == H_DUMMY &&
                               cnt_q == dummy_clocks(op_q, four_byte_addr_mode) - 6'd1) begin
                     cnt_q   <= 6'd0;
                     state_q <= H_DATA;
                  end else if (last_bit) begin
                     state_q <= H_END;
                  end
               end else if (fall_t) begin
                  if (state_q == H_CMD || state_q == H_ADDR) begin
                     dq_o_q  <= lane_pack(tx_q[39:32], w, 1'b0);
                     dq_oe_q <= lane_oe(w, 1'b0);
                     tx_q    <= tx_q << w;
                  end else begin
                     dq_oe_q <= 4'h0;
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // receive bytes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_q       <= 8'h00;
         rbit_q     <= 4'h0;
         left_q     <= 9'd0;
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= 1'b0;
         if (state_q == H_IDLE && start) begin
            rbit_q <= 4'h0;
            left_q <= {read_len == 8'h00, read_len};
         end else if (rise_t && state_q == H_DATA) begin
            rx_q <= rx_next[7:0];
            if ({1'b0, rbit_q} + {2'b00, w} == 5'd8) begin
               rbit_q     <= 4'h0;
               rd_data_q  <= rx_next[7:0];
               rd_valid_q <= 1'b1;
               left_q     <= left_q - 9'd1;
            end else begin
               rbit_q <= rbit_q + {1'b0, w};
            end
         end
      end
   end

endmodule : fidr_host

// ---- hdl/fidr_device.sv ----
// Functional notes
// - dual ID: address, mode two bits per clock
// - address zero manufacturer first, one device first
// - alternate ID bytes until chip select rises
// - host sends mode upper nibble as ones
// - quad ID: four bits, four dummy clocks
// - dual/quad ID refused in four-line mode
// - unique ID after four or five dummy bytes
// - standard ID: three bytes, both command modes
// - table read: address, eight dummy clocks
// - table address high bits zero, low select
// - table header signature, revision, one header
// - reserved table bytes read as FFh
// - byte 80h E5h, byte 81h 20h
// - byte 82h reads F1h
// - density bytes little-endian, 256 megabits
// - fast read settings and opcodes reported
// - four-line read fields and opcode reported
// - erase type sizes and opcodes reported
`timescale 1ns/10ps
module fidr_device
   import fidr_pkg::*;
#(
   // identity values are arbitrary
   parameter logic [7:0]  MFR_ID    = 8'h5c,
   parameter logic [7:0]  DEV_ID    = 8'h18,
   parameter logic [7:0]  MEM_TYPE  = 8'h40,
   parameter logic [7:0]  CAPACITY  = 8'h19,
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef
)
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // flash link
   fidr_link_if.dev  link,
   // mode straps
   input  wire logic four_line_command_mode,
   input  wire logic four_byte_addr_mode,
   // status
   output logic      out_active_q
);

   // ---------------------------------------------------------------
   // discoverable parameter table
   // ---------------------------------------------------------------
   localparam logic [7:0] TBL_RESERVED     = 8'hff;
   localparam logic [7:0] TBL_HEADER_COUNT = 8'h00;
   localparam logic [7:0] TBL_PARAM_LEN    = 8'h09;
   localparam logic [7:0] TBL_PARAM_PTR    = 8'h80;

   function automatic logic [7:0] disc_byte(input logic [7:0] a);
      case (a)
         8'h00: return 8'h53;
         8'h01: return 8'h46;
         8'h02: return 8'h44;
         8'h03: return 8'h53;
         8'h04: return 8'h00;
         8'h05: return 8'h01;
         8'h06: return TBL_HEADER_COUNT;
         8'h08: return 8'h00;
         8'h09: return 8'h00;
         8'h0a: return 8'h01;
         8'h0b: return TBL_PARAM_LEN;
         8'h0c: return TBL_PARAM_PTR;
         8'h0d: return 8'h00;
         8'h0e: return 8'h00;
         8'h80: return 8'he5;
         8'h81: return 8'h20;
         8'h82: return 8'hf1;
         8'h87: return 8'h0f;
         8'h88: return 8'h44;
         8'h89: return 8'heb;
         8'h8a: return 8'h08;
         8'h8b: return 8'h6b;
         8'h8c: return 8'h08;
         8'h8d: return 8'h3b;
         8'h8e: return 8'h80;
         8'h8f: return 8'hbb;
         8'h90: return 8'hfe;
         8'h96: return 8'h00;
         8'h97: return 8'h00;
         8'h9a: return 8'h08;
         8'h9b: return 8'heb;
         8'h9c: return 8'h0c;
         8'h9d: return 8'h20;
         8'h9e: return 8'h0f;
         8'h9f: return 8'h52;
         8'ha0: return 8'h10;
         8'ha1: return 8'hd8;
         8'ha2: return 8'h00;
         8'ha3: return 8'h00;
         default: return TBL_RESERVED;
      endcase
   endfunction : disc_byte

   function automatic logic [7:0] fetch_byte(input logic [7:0] op, input logic [7:0] idx);
      case (op)
         OP_ID_DUAL,
         OP_ID_QUAD:   return idx[0] ? DEV_ID : MFR_ID;
         OP_UNIQUE_ID: return UNIQUE_ID[8 * (7 - idx[2:0]) +: 8];
         OP_STD_ID:    return (idx == 8'd0) ? MFR_ID : (idx == 8'd1) ? MEM_TYPE : CAPACITY;
         default:      return disc_byte(idx);
      endcase
   endfunction : fetch_byte

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   fidr_phase_t phase_q;
   logic        sclk_q;
   logic [5:0]  cnt_q;
   logic [7:0]  op_q;
   logic [31:0] in_sr_q;
   logic [7:0]  idx_q;
   logic [7:0]  sh_q;
   logic [3:0]  obit_q;
   logic [3:0]  dq_o_q;
   logic [3:0]  dq_oe_q;
   logic        rise;
   logic        fall;
   logic [2:0]  in_w;
   logic [2:0]  out_w;
   logic [31:0] sr_next;
   logic [7:0]  op_next;
   logic [7:0]  cur_byte;

   assign link.dq_d_o  = dq_o_q;
   assign link.dq_d_oe = dq_oe_q;

   assign rise     = ~link.cs_b & link.sclk & ~sclk_q;
   assign fall     = ~link.cs_b & ~link.sclk & sclk_q;
   assign in_w     = (phase_q == PH_CMD) ? cmd_width(four_line_command_mode) : addr_width(op_q);
   assign out_w    = data_width(op_q, four_line_command_mode);
   assign sr_next  = shift_in(in_sr_q, link.dq, in_w, 1'b0);
   assign op_next  = sr_next[7:0];
   assign cur_byte = fetch_byte(op_q, idx_q);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         sclk_q <= 1'b0;
      else
         sclk_q <= link.sclk;
   end

   // ---------------------------------------------------------------
   // command, address and dummy phases
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= PH_CMD;
         cnt_q   <= 6'd0;
         op_q    <= 8'h00;
         in_sr_q <= 32'h0;
         idx_q   <= 8'h00;
      end else if (link.cs_b) begin
         phase_q <= PH_CMD;
         cnt_q   <= 6'd0;
         in_sr_q <= 32'h0;
      end else if (rise) begin
         unique case (phase_q)
            PH_CMD: begin
               in_sr_q <= sr_next;
               cnt_q   <= cnt_q + 6'd1;
               if (cnt_q == cmd_clocks(four_line_command_mode) - 6'd1) begin
                  op_q  <= op_next;
                  cnt_q <= 6'd0;
                  idx_q <= 8'h00;
                  if (!op_accepted(op_next, four_line_command_mode))
                     phase_q <= PH_SKIP;
                  else if (addr_clocks(op_next) != 6'd0)
                     phase_q <= PH_ADDR;
                  else if (dummy_clocks(op_next, four_byte_addr_mode) != 6'd0)
                     phase_q <= PH_DUMMY;
                  else
                     phase_q <= PH_DATA;
               end
            end
            PH_ADDR: begin
               in_sr_q <= sr_next;
               cnt_q   <= cnt_q + 6'd1;
               if (cnt_q == addr_clocks(op_q) - 6'd1) begin
                  cnt_q   <= 6'd0;
                  phase_q <= (dummy_clocks(op_q, four_byte_addr_mode) != 6'd0) ? PH_DUMMY
                                                                               : PH_DATA;
                  idx_q   <= (op_q == OP_DISC_READ) ? sr_next[7:0] : {7'd0, sr_next[8]};
               end
            end
            PH_DUMMY: begin
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == dummy_clocks(op_q, four_byte_addr_mode) - 6'd1) begin
                  cnt_q   <= 6'd0;
                  phase_q <= PH_DATA;
               end
            end
            PH_DATA, PH_SKIP: cnt_q <= 6'd0;
            default: phase_q <= PH_SKIP;
         endcase
      end else if (fall && phase_q == PH_DATA && obit_q == 4'd0) begin
         idx_q <= (op_q == OP_STD_ID && idx_q == 8'd2) ? 8'd0 : idx_q + 8'd1;
      end
   end

   // ---------------------------------------------------------------
   // output lanes, driven on falling serial clock
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_q    <= 8'h00;
         obit_q  <= 4'd0;
         dq_o_q  <= 4'h0;
         dq_oe_q <= 4'h0;
      end else if (link.cs_b) begin
         obit_q  <= 4'd0;
         dq_o_q  <= 4'h0;
         dq_oe_q <= 4'h0;
      end else if (fall && phase_q == PH_DATA) begin
         if (obit_q == 4'd0) begin
            dq_o_q  <= lane_pack(cur_byte, out_w, 1'b1);
            dq_oe_q <= lane_oe(out_w, 1'b1);
            sh_q    <= cur_byte << out_w;
            obit_q  <= 4'd8 - {1'b0, out_w};
         end else begin
            dq_o_q <= lane_pack(sh_q, out_w, 1'b1);
            sh_q   <= sh_q << out_w;
            obit_q <= obit_q - {1'b0, out_w};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         out_active_q <= 1'b0;
      else
         out_active_q <= ~link.cs_b & (phase_q == PH_DATA);
   end

endmodule : fidr_device

// ---- bench/fidr_asserts.sv ----
`timescale 1ns/10ps
module fidr_asserts (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_b,
   // link
   input wire logic       cs_b,
   input wire logic       sclk,
   input wire logic [3:0] dq_h_oe,
   input wire logic [3:0] dq_d_o,
   input wire logic [3:0] dq_d_oe
);
   logic       sclk1_q;
   logic       sclk2_q;
   logic [3:0] rise_q;
   wire        fall = sclk2_q & ~sclk1_q;
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // edge history and rise count
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk1_q <= 1'b0;
         sclk2_q <= 1'b0;
      end else begin
         sclk1_q <= sclk;
         sclk2_q <= sclk1_q;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         rise_q <= 4'h0;
      else if (cs_b)
         rise_q <= 4'h0;
      else if (sclk && !sclk1_q && rise_q != 4'hf)
         rise_q <= rise_q + 4'h1;
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_cs_release: assert property (cs_b |=> dq_d_oe == 4'h0)
      else $error("device drives with chip select high");
   a_no_contend: assert property ((dq_d_oe & dq_h_oe) == 4'h0)
      else $error("host and device drive one lane");
   a_lane_width: assert property (dq_d_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("device lane set illegal");
   a_data_on_fall: assert property (!cs_b && $changed(dq_d_o) |-> fall)
      else $error("device data moved off a falling clock");
   a_oe_on_fall: assert property ($changed(dq_d_oe) |-> fall || $past(cs_b))
      else $error("device enable moved off a falling clock");
   a_sclk_idle: assert property (cs_b |-> !sclk)
      else $error("serial clock high outside frame");
   a_sclk_half: assert property ($rose(sclk) |-> sclk[*2] ##1 !sclk)
      else $error("serial clock high time wrong");
   a_opcode_quiet: assert property (rise_q < 4'd2 |-> dq_d_oe == 4'h0)
      else $error("device drives during opcode");
   c_single: cover property (dq_d_oe == 4'h2);
   c_dual: cover property (dq_d_oe == 4'h3);
   c_quad: cover property (dq_d_oe == 4'hf);
endmodule : fidr_asserts

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb
   import fidr_pkg::*;
;
   // identity values are arbitrary
   localparam logic [7:0]   MFR = 8'h3c;
   localparam logic [7:0]   DEV = 8'h27;
   localparam logic [23:0]  JID = {MFR, 8'h61, 8'h1a};
   localparam logic [63:0]  UID = 64'hfeed_0bad_1357_9ace;
   localparam logic [127:0] HDR = 128'h5346_4453_0001_00ff_0000_0109_8000_00ff;
   localparam logic [287:0] PAR = {144'he520_f1ff_ffff_ff0f_44eb_086b_083b_80bb_feff,
                                   144'hffff_ffff_0000_ffff_08eb_0c20_0f52_10d8_0000};
   logic        ref_clk = 1'b0, rst_b = 1'b0, start = 1'b0, fl = 1'b0, fb = 1'b0, act;
   logic [7:0]  cmd_op = 8'h00, read_len = 8'h00, rd_data_q;
   logic [23:0] cmd_addr = 24'h0;
   logic        busy_q, rd_valid_q, out_active_q;
   logic [7:0]  got[$];
   int          fails = 0, check_count = 0;
   always #20 ref_clk = ~ref_clk;
   fidr_link_if link_i ();
   fidr_host fidr_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link_i), .start(start),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .read_len(read_len), .four_line_command_mode(fl),
      .four_byte_addr_mode(fb), .busy_q(busy_q), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q));
   fidr_device #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(JID[15:8]), .CAPACITY(JID[7:0]),
      .UNIQUE_ID(UID)) fidr_device_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link_i),
      .four_line_command_mode(fl), .four_byte_addr_mode(fb), .out_active_q(out_active_q));
   fidr_asserts fidr_asserts_i (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(link_i.cs_b),
      .sclk(link_i.sclk), .dq_h_oe(link_i.dq_h_oe), .dq_d_o(link_i.dq_d_o),
      .dq_d_oe(link_i.dq_d_oe));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n,
                       input logic f4, input logic f5);
      int k;
      k = 0;
      got = {};
      act = 1'b0;
      @(posedge ref_clk);
      #1;
      {cmd_op, cmd_addr, read_len, fl, fb} = {op, a, n, f4, f5};
      start = 1'b1;
      @(posedge ref_clk);
      #1;
      start = 1'b0;
      while (busy_q !== 1'b0 && k < 20000) begin
         @(negedge ref_clk);
         k++;
         if (rd_valid_q === 1'b1)
            got.push_back(rd_data_q);
         if (out_active_q === 1'b1)
            act = 1'b1;
      end
      if (k >= 20000) begin
         fails++;
         end_sim();
      end else
         chk(8'(got.size()), n);
   endtask : xfer
   function automatic logic [7:0] table_byte(input logic [7:0] i);
      if (i < 8'h10)
         return HDR[8*(15-i) +: 8];
      if (i >= 8'h80 && i < 8'ha4)
         return PAR[8*(163-i) +: 8];
      return 8'hff;
   endfunction : table_byte
   task automatic t_std_id(input logic f4);
      xfer(OP_STD_ID, 24'h0, 8'd6, f4, 1'b0);
      chk({7'h0, act}, 8'h01);
      for (int i = 0; i < 6; i++)
         chk(got[i], JID[8*(2-i%3) +: 8]);
   endtask : t_std_id
   task automatic t_id(input logic [7:0] op, input logic a0);
      xfer(op, {23'h0, a0}, 8'd5, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++)
         chk(got[i], ((i + a0) % 2 == 0) ? MFR : DEV);
   endtask : t_id
   task automatic t_uid(input logic f5);
      xfer(OP_UNIQUE_ID, 24'h0, 8'd8, 1'b0, f5);
      for (int i = 0; i < 8; i++)
         chk(got[i], UID[8*(7-i) +: 8]);
   endtask : t_uid
   task automatic t_refused(input logic [7:0] op);
      xfer(op, 24'h0, 8'd2, 1'b1, 1'b0);
      chk({7'h0, act}, 8'h00);
      for (int i = 0; i < 2; i++)
         chk(got[i], 8'hff);
   endtask : t_refused
   task automatic t_table(input logic [7:0] a, input logic [7:0] n);
      xfer(OP_DISC_READ, {16'h0, a}, n, 1'b0, 1'b0);
      for (int i = 0; i < got.size(); i++) begin
         if (a + 8'(i) < 8'h88)
            chk(got[i], table_byte(a + 8'(i)));
         else
            chk(got[i], table_byte(a + 8'(i)));
      end
   endtask : t_table
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      t_std_id(1'b0);
      t_std_id(1'b1);
      t_id(OP_ID_DUAL, 1'b0);
      t_id(OP_ID_DUAL, 1'b1);
      t_id(OP_ID_QUAD, 1'b0);
      t_id(OP_ID_QUAD, 1'b1);
      t_uid(1'b0);
      t_uid(1'b1);
      t_refused(OP_ID_DUAL);
      t_refused(OP_ID_QUAD);
      t_refused(OP_UNIQUE_ID);
      t_refused(OP_DISC_READ);
      t_table(8'h00, 8'h00);
      t_table(8'hfe, 8'h04);
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      end_sim();
   end
endmodule : tb
